// ### ibsc_bus_peer.sv
// Behavioural bus master on the far side of the block
`timescale 1ns/100ps
module ibsc_bus_peer (
  // Enables from the block
  input  wire logic SCL_OE,
  input  wire logic SDA_OE,
  // Wired levels with pull-ups
  output logic      SCL_IN,
  output logic      SDA_IN
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic ack_q = 1'b1;
  assign SCL_IN = scl_q && !SCL_OE;
  assign SDA_IN = sda_q && !SDA_OE;
  task automatic start_cond();
    #3 sda_q = 1'b0;
    #32 scl_q = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] v);
    for (int i = 8; i >= 0; i--) begin
      #19 sda_q = (i == 0) ? 1'b1 : v[i-1];
      #16 scl_q = 1'b1;
      #16 ack_q = SDA_IN;
      #13 scl_q = 1'b0;
    end
  endtask
  task automatic stop_cond();
    #19 sda_q = 1'b0;
    #16 scl_q = 1'b1;
    #16 sda_q = 1'b1;
    #16;
  endtask
endmodule

// ### ibsc_pkg.sv
// Package for the bus status and control block
package ibsc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_OWN    = 8'h0C;
  localparam logic [7:0] ADDR_IRQST  = 8'h10;
  localparam logic [7:0] ADDR_IRQMSK = 8'h14;
  localparam logic [7:0] STATUS_RESET = 8'h30;
  // Status bit positions
  localparam int B_BUSY = 7;
  localparam int B_IRQ  = 6;
  localparam int B_SSI  = 5;
  localparam int B_ARB  = 3;
  localparam int B_OWN  = 2;
  localparam int B_GC   = 1;
  localparam int B_ACK  = 0;
  // Control bit positions
  localparam int C_EN   = 0;
  localparam int C_MST  = 1;
  localparam int C_TRS  = 2;
  localparam int C_FS   = 3;
  // Interrupt status bits
  localparam int I_IRQ  = 0;
  localparam int I_ARB  = 1;
  localparam int I_GC   = 2;
  localparam int I_STOP = 3;
  localparam int IRQ_W  = 4;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [3:0] BIT_LAST = 4'h8;
  // Bit count after a start; the following SCL fall wraps it to zero
  localparam logic [3:0] BIT_PRE  = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_SKIP = 2'b11
  } ibsc_state_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_p;
    logic       sda_p;
    ibsc_state_t st;
    logic [3:0] bitn;
    logic [7:0] shf;
    logic       gc_hit;
    logic       own_hit;
    logic       en;
    logic       mst;
    logic       trs;
    logic       fs;
    logic       ack;
    logic       irq;
    logic       arb;
    logic       own;
    logic       gc;
    logic       busy;
    logic       rd_gc;
    logic       rd_arb;
    logic [7:0] data;
    logic [7:0] tx;
    logic [6:0] own_addr;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic       sda_oe;
    logic       scl_oe;
    logic       req_start;
    logic       req_stop;
    logic [31:0] prdata;
    logic       pready;
    logic       intr;
    logic       port_mode;
  } ibsc_regs_t;
endpackage

// ### ibsc_top.sv
// Bus status and control block with APB register access
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
// What this block does
// - Disabled: pins behave as plain ports
// - Enabled: module may drive SDA; SCL_OE stays low, so SCL is never driven
// - Receive: drive acknowledge value in slot
// - Transmit: acknowledge value latches receiver answer
// - General call sets general call flag
// - Read one then write zero clears general call
// - Own or general address sets match flag
// - Data read while receiving or data write while transmitting clears three flags
// - Master transmit SDA mismatch sets arbitration lost
// - Read one then write zero clears arbitration
// - Inhibit zero with busy issues start/stop
// - Start/stop inhibit always reads one
// - Busy flag follows detected bus activity
// - Slave match and byte ends raise request when FS is clear
// - General call and following bytes raise request
module ibsc_top
  import ibsc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // I2C pins
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  // Port mode, start/stop requests and interrupt
  output logic             PINS_AS_PORT,
  output logic             START_REQ,
  output logic             STOP_REQ,
  output logic             IRQ
);
  ibsc_regs_t q;
  ibsc_regs_t d;
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  logic wr, rd;
  logic [7:0] status_rd;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], SCL_IN};
    d.sda_s = {q.sda_s[0], SDA_IN};
    scl = q.scl_s[1];
    sda = q.sda_s[1];
    d.scl_p = scl;
    d.sda_p = sda;
    scl_rise = scl & ~q.scl_p;
    scl_fall = ~scl & q.scl_p;
    start_c = scl & q.scl_p & q.sda_p & ~sda;
    stop_c = scl & q.scl_p & ~q.sda_p & sda;
    wr = PSEL & PENABLE & PWRITE & ~q.pready;
    rd = PSEL & PENABLE & ~PWRITE & ~q.pready;
    status_rd = {q.busy, q.irq, 1'b1, 1'b1, q.arb, q.own, q.gc, q.ack};
    d.pready = PSEL & PENABLE & ~q.pready;
    d.prdata = 32'h0000_0000;
    d.req_start = 1'b0;
    d.req_stop = 1'b0;
    // Bus activity tracking
    if (start_c) begin
      d.busy = 1'b1;
    end else if (stop_c) begin
      d.busy = 1'b0;
    end
    // Slave receive / transfer engine
    if (!q.en || stop_c) begin
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
      d.gc_hit = 1'b0;
      d.own_hit = 1'b0;
    end else if (start_c) begin
      d.st = ST_ADDR;
      d.bitn = BIT_PRE;
      d.gc_hit = 1'b0;
      d.own_hit = 1'b0;
      d.sda_oe = 1'b0;
    end else if (scl_rise && q.st != ST_IDLE) begin
      if (q.bitn < BIT_LAST) begin
        d.shf = {q.shf[6:0], sda};
        if (q.mst && q.trs && q.sda_oe == 1'b0 && q.tx[7] == 1'b0 && sda) begin
          d.arb = 1'b1;
        end
        if (q.mst && q.trs && q.tx[7] && ~sda && q.st == ST_DATA) begin
          d.arb = 1'b1;
        end
      end else begin
        if (q.trs) begin
          d.ack = sda;
        end
        if (q.st == ST_ADDR) begin
          if (q.shf[7:1] == GC_ADDR && !q.shf[0] && !q.mst) begin
            d.gc = 1'b1;
            d.own = 1'b1;
            d.gc_hit = 1'b1;
            d.irq = 1'b1;
            d.st = ST_DATA;
          end else if (q.shf[7:1] == q.own_addr && !q.mst) begin
            d.own = 1'b1;
            d.own_hit = 1'b1;
            if (!q.fs) begin
              d.irq = 1'b1;
            end
            d.st = ST_DATA;
          end else begin
            d.st = q.mst ? ST_DATA : ST_SKIP;
          end
        end else if (q.st == ST_DATA) begin
          if ((q.own_hit && !q.fs) || q.gc_hit || q.mst) begin
            d.irq = 1'b1;
          end
        end
      end
    end else if (scl_fall && q.st != ST_IDLE) begin
      d.bitn = (q.bitn == BIT_LAST) ? 4'h0 : q.bitn + 4'h1;
      d.sda_oe = 1'b0;
      if (q.bitn == 4'h7 && !q.trs && q.st == ST_DATA) begin
        d.sda_oe = ~q.ack;
      end
      if (q.bitn == 4'h7 && q.st == ST_ADDR && !q.mst) begin
        d.sda_oe = ((q.shf[7:1] == q.own_addr) || (q.shf[7:1] == GC_ADDR)) && !q.shf[0];
      end
      if (q.bitn != 4'h7 && q.trs && q.st == ST_DATA) begin
        d.sda_oe = ~q.tx[7];
        d.tx = {q.tx[6:0], 1'b1};
      end
    end
    // Register reads
    if (rd) begin
      unique case (PADDR)
        ADDR_STATUS: begin
          d.prdata = {24'h00_0000, status_rd};
          d.rd_gc = q.gc;
          d.rd_arb = q.arb;
        end
        ADDR_CTRL: d.prdata = {28'h000_0000, q.fs, q.trs, q.mst, q.en};
        ADDR_DATA: begin
          d.prdata = {24'h00_0000, q.data};
          if (!q.trs) begin
            d.gc = d.gc & ~q.gc;
            d.own = d.own & ~q.own;
            d.arb = d.arb & ~q.arb;
          end
        end
        ADDR_OWN: d.prdata = {25'h000_0000, q.own_addr};
        ADDR_IRQST: d.prdata = {28'h000_0000, q.ist};
        ADDR_IRQMSK: d.prdata = {28'h000_0000, q.imsk};
        default: d.prdata = 32'h0000_0000;
      endcase
    end
    if (scl_rise && q.bitn == BIT_LAST && q.st == ST_DATA && !q.trs) begin
      d.data = q.shf;
    end
    // Register writes
    if (wr) begin
      unique case (PADDR)
        ADDR_STATUS: begin
          d.ack = PWDATA[B_ACK];
          if (!PWDATA[B_IRQ]) begin
            d.irq = d.irq & ~q.irq;
          end
          if (!PWDATA[B_GC] && q.rd_gc) begin
            d.gc = d.gc & ~q.gc;
          end
          if (!PWDATA[B_ARB] && q.rd_arb) begin
            d.arb = d.arb & ~q.arb;
          end
          if (!PWDATA[B_SSI] && q.en) begin
            d.req_start = PWDATA[B_BUSY];
            d.req_stop = ~PWDATA[B_BUSY];
            d.busy = PWDATA[B_BUSY];
          end
        end
        ADDR_CTRL: begin
          d.en = PWDATA[C_EN];
          d.mst = PWDATA[C_MST];
          d.trs = PWDATA[C_TRS];
          d.fs = PWDATA[C_FS];
        end
        ADDR_DATA: begin
          d.tx = PWDATA[7:0];
          if (q.trs) begin
            d.gc = d.gc & ~q.gc;
            d.own = d.own & ~q.own;
            d.arb = d.arb & ~q.arb;
          end
        end
        ADDR_OWN: d.own_addr = PWDATA[6:0];
        ADDR_IRQST: d.ist = q.ist;
        ADDR_IRQMSK: d.imsk = PWDATA[IRQ_W-1:0];
        default: d.req_start = 1'b0;
      endcase
    end
    // Sticky events; read clears, new event wins
    if (rd && PADDR == ADDR_IRQST) begin
      d.ist = '0;
    end
    if (d.irq && !q.irq) d.ist[I_IRQ] = 1'b1;
    if (d.arb && !q.arb) d.ist[I_ARB] = 1'b1;
    if (d.gc && !q.gc) d.ist[I_GC] = 1'b1;
    if (stop_c) d.ist[I_STOP] = 1'b1;
    d.intr = |(d.ist & d.imsk);
    d.scl_oe = 1'b0;
    d.port_mode = ~d.en;
    if (!q.en) begin
      d.sda_oe = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      q <= '0;
      q.scl_s <= 2'b11;
      q.sda_s <= 2'b11;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.st <= ST_IDLE;
      q.port_mode <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = 1'b0;
  assign SCL_OUT = 1'b0;
  assign SCL_OE = q.scl_oe;
  assign SDA_OUT = 1'b0;
  assign SDA_OE = q.sda_oe;
  assign PINS_AS_PORT = q.port_mode;
  assign START_REQ = q.req_start;
  assign STOP_REQ = q.req_stop;
  assign IRQ = q.intr;
endmodule

// ### ibsc_top_properties.sv
// Port assertions for the bus status and control block
`timescale 1ns/100ps
module ibsc_top_properties
  import ibsc_pkg::*;
(
  // APB side
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  // Pin side
  input wire logic        SCL_OE,
  input wire logic        SDA_OE,
  input wire logic        PINS_AS_PORT,
  input wire logic        START_REQ,
  input wire logic        STOP_REQ,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  logic sw;
  assign sw = PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_STATUS && !PWDATA[B_SSI] && !PINS_AS_PORT;
  chk_port_idle: assert property (PINS_AS_PORT |-> !SDA_OE && !SCL_OE)
    else $error("pin driven");
  chk_port_nocond: assert property (PINS_AS_PORT |-> !START_REQ && !STOP_REQ)
    else $error("condition while off");
  chk_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  chk_inhibit_one: assert property (PREADY && !PWRITE && PADDR == ADDR_STATUS |-> PRDATA[B_SSI] && PRDATA[4])
    else $error("inhibit read zero");
  chk_start_req: assert property (sw && PWDATA[B_BUSY] |-> ##[0:1] START_REQ)
    else $error("no start");
  chk_stop_req: assert property (sw && !PWDATA[B_BUSY] |-> ##[0:1] STOP_REQ)
    else $error("no stop");
  chk_cond_once: assert property (START_REQ || STOP_REQ |=> !START_REQ && !STOP_REQ)
    else $error("condition held");
  chk_irq_mask: assert property (PREADY && PWRITE && PADDR == ADDR_IRQMSK && PWDATA[3:0] == 4'h0 |-> ##2 !IRQ)
    else $error("masked irq");
endmodule

// ### test_ibsc_top.sv
// Directed bench for the bus status and control block
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_ibsc_top;
  import ibsc_pkg::*;
  logic        clock, reset, psel, penable, pwrite, ready, port_mode, irq;
  logic        scl_oe, sda_oe, scl_in, sda_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, check_count;
  ibsc_top DUT (.CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(ready), .PSLVERR(), .SCL_IN(scl_in), .SCL_OUT(), .SCL_OE(scl_oe),
    .SDA_IN(sda_in), .SDA_OUT(), .SDA_OE(sda_oe), .PINS_AS_PORT(port_mode), .START_REQ(), .STOP_REQ(), .IRQ(irq));
  ibsc_bus_peer peer (.SCL_OE(scl_oe), .SDA_OE(sda_oe), .SCL_IN(scl_in), .SDA_IN(sda_in));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (ready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    `CHECK(nm, ex, rd)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    fail_count = 0;
    check_count = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdc(ADDR_STATUS, 32'h0000_0030, "reset");
    `CHECK("port", 1'b1, port_mode)
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, ADDR_OWN, 32'h0000_002A);
    apb(1'b1, ADDR_IRQMSK, 32'h0000_000F);
    `CHECK("port", 1'b0, port_mode)
    peer.start_cond();
    rdc(ADDR_STATUS, 32'h0000_00B0, "busy");
    peer.send_byte(8'h54);
    `CHECK("ack", 1'b0, peer.ack_q)
    rdc(ADDR_STATUS, 32'h0000_00F4, "match");
    `CHECK("irq", 1'b1, irq)
    apb(1'b0, ADDR_DATA, 32'h0000_0000);
    rdc(ADDR_STATUS, 32'h0000_00F0, "dread");
    apb(1'b1, ADDR_STATUS, 32'h0000_0021);
    peer.send_byte(8'hC3);
    `CHECK("nack", 1'b1, peer.ack_q)
    rdc(ADDR_STATUS, 32'h0000_00F1, "byte");
    rdc(ADDR_DATA, 32'h0000_00C3, "data");
    apb(1'b1, ADDR_IRQMSK, 32'h0000_0000);
    repeat (2) @(posedge clock);
    `CHECK("mask", 1'b0, irq)
    rdc(ADDR_IRQST, 32'h0000_0001, "ist");
    rdc(ADDR_IRQST, 32'h0000_0000, "ist_clr");
    apb(1'b1, ADDR_STATUS, 32'h0000_0020);
    peer.stop_cond();
    rdc(ADDR_STATUS, 32'h0000_0030, "stop");
    peer.start_cond();
    peer.send_byte(8'h00);
    rdc(ADDR_STATUS, 32'h0000_00F6, "gcall");
    apb(1'b1, ADDR_STATUS, 32'h0000_0024);
    rdc(ADDR_STATUS, 32'h0000_00B4, "gc_clr");
    peer.stop_cond();
    apb(1'b1, ADDR_STATUS, 32'h0000_0080);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHECK("start", 1'b1, rd[B_BUSY])
    apb(1'b1, ADDR_STATUS, 32'h0000_0000);
    rdc(8'hFC, 32'h0000_0000, "unmapped");
    report_and_stop();
  end
endmodule
bind ibsc_top ibsc_top_properties chk (.CLOCK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PREADY, .SCL_OE, .SDA_OE, .PINS_AS_PORT, .START_REQ, .STOP_REQ, .IRQ);
